// ---- hdl/subcmd_regs.svh ----
`ifndef SUBCMD_REGS_SVH
`define SUBCMD_REGS_SVH

// Subcommand codes
`define CMD_PART_ID          16'h0001
`define CMD_FIRMWARE_INFO    16'h0002
`define CMD_SILICON_REVISION 16'h0003
`define CMD_UNLOCK_KEY       16'h0035
`define CMD_BALANCING_MASK   16'h0083
`define CMD_WAKE_TIMER       16'h0094
`define CMD_FAULT_RECOVERY   16'h009b

// Answer lengths in bytes
`define LEN_NONE     3'h0
`define LEN_BYTE     3'h1
`define LEN_WORD     3'h2
`define LEN_FIRMWARE 3'h6

// Balancing mask: bits 1..5 are cells, 0/6/7 reserved
`define BAL_VALID_MASK 8'h3e
`define BAL_RESET      8'h00

// Wake timer control field positions
`define WT_CODE_LSB     0
`define WT_CODE_MSB     7
`define WT_SD_BIT       8
`define WT_DLY_LSB      9
`define WT_DLY_MSB      10
`define WT_ALARM_BIT    11
`define WT_CTRL_MSB     11
`define WT_CTRL_RESET   12'h000

// Fault recovery field positions
`define REC_LSB   1
`define REC_MSB   7
`define REC_RESET 7'h00

// Regulator control register fields
`define REG_EN_BIT    3
`define REG_VOLT_LSB  0
`define REG_VOLT_MSB  2

// Wake timer code ranges
`define WT_FINE_LAST   8'h10
`define WT_COARSE_BIAS 10'h00c

// Timing
`define CLK_KHZ          125000
`define WAKE_TICK_MS     250
`define UNLOCK_WINDOW_MS 5000

`endif

// ---- hdl/subcmd_pkg.sv ----
package subcmd_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] code;
        logic [31:0] data;
    } subcmd_req_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  len;
        logic [47:0] data;
    } subcmd_rsp_t;

    typedef struct packed {
        logic       alarm_wake_enable;
        logic [1:0] shutdown_delay_select;
        logic       timer_shutdown_enable;
        logic [7:0] wake_timer_code;
    } wake_timer_ctrl_t;

    typedef struct packed {
        logic cell_voltage_fault_clear;
        logic diagnostic_fault_clear;
        logic short_circuit_fault_clear;
        logic discharge_overcurrent_a_clear;
        logic discharge_overcurrent_b_clear;
        logic charge_overcurrent_clear;
        logic temperature_fault_clear;
    } fault_recovery_t;

    typedef struct packed {
        logic       enable;
        logic [2:0] voltage;
    } regulator_setting_t;

    typedef enum logic {
        TMR_IDLE,
        TMR_RUN
    } timer_state_t;

endpackage

// ---- hdl/wake_timer.sv ----
`timescale 1ns/1ps
`include "subcmd_regs.svh"

module wake_timer
    import subcmd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `WAKE_TICK_MS * `CLK_KHZ
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Control
    input  wire logic             i_start,
    input  wire logic             i_stop,
    input  wire wake_timer_ctrl_t i_ctrl,
    input  wire logic             i_reg_powered,
    input  wire logic             i_alarm_any,
    // Status
    output logic                  o_running,
    output logic                  o_hold_off
);

    localparam int PW = $clog2(TICK_CYCLES + 1);

    if (TICK_CYCLES < 1) begin : g_chk
        $error("TICK_CYCLES must be at least one");
    end

    function automatic logic [9:0] duration(input logic [7:0] code);
        logic [9:0] c;
        c = {2'b00, code};
        if (code <= `WT_FINE_LAST) begin
            duration = c;
        end else begin
            duration = (c - `WT_COARSE_BIAS) << 2;
        end
    endfunction

    function automatic logic [9:0] delay_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h0: delay_ticks = 10'h000;
            2'h1: delay_ticks = 10'h001;
            2'h2: delay_ticks = 10'h004;
            2'h3: delay_ticks = 10'h010;
        endcase
    endfunction

    timer_state_t     state;
    wake_timer_ctrl_t ctrl;
    logic [PW-1:0]    pre;
    logic [9:0]       elapsed;
    logic             shut_pending;

    wire        tick         = (pre == PW'(TICK_CYCLES - 1));
    wire [9:0]  next_elapsed = elapsed + 10'h001;
    wire        expire       = tick && (next_elapsed == duration(ctrl.wake_timer_code));
    wire        shut_due     = shut_pending && tick &&
                               (next_elapsed == delay_ticks(ctrl.shutdown_delay_select));
    wire        alarm_wake   = i_alarm_any && ctrl.alarm_wake_enable &&
                               ctrl.timer_shutdown_enable;
    wire        sd_now       = i_ctrl.timer_shutdown_enable && i_reg_powered;
    wire        no_delay     = (i_ctrl.shutdown_delay_select == 2'h0);

    assign o_running = (state == TMR_RUN);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state        <= TMR_IDLE;
            ctrl         <= `WT_CTRL_RESET;
            pre          <= '0;
            elapsed      <= 10'h000;
            shut_pending <= 1'b0;
            o_hold_off   <= 1'b0;
        end else if (i_start) begin
            state        <= TMR_RUN;
            ctrl         <= i_ctrl;
            pre          <= '0;
            elapsed      <= 10'h000;
            shut_pending <= sd_now && !no_delay;
            o_hold_off   <= o_hold_off || (sd_now && no_delay);
        end else if (i_stop) begin
            state        <= TMR_IDLE;
            shut_pending <= 1'b0;
            o_hold_off   <= 1'b0;
        end else if (state == TMR_RUN) begin
            pre <= tick ? '0 : pre + PW'(1);
            if (tick) begin
                elapsed <= next_elapsed;
            end
            if (expire) begin
                state        <= TMR_IDLE;
                shut_pending <= 1'b0;
                o_hold_off   <= 1'b0;
            end else if (alarm_wake) begin
                shut_pending <= 1'b0;
                o_hold_off   <= 1'b0;
            end else if (shut_due) begin
                shut_pending <= 1'b0;
                o_hold_off   <= 1'b1;
            end
        end
    end

endmodule

// ---- hdl/subcommand_data_fields.sv ----
// Behaviour
// - Part id read answers two bytes, low byte first.
// - Firmware read answers part id, version, BCD build, each high byte first.
// - Silicon revision read answers a fixed 16-bit word.
// - Full access granted only when both key words match.
// - Second key within 5 s of first, nothing in between.
// - Balancing mask read shows cells now balanced.
// - Writing mask starts balancing set cells; zero stops all.
// - Bits 1..5 are cells; bits 0, 6, 7 read zero.
// - Timer codes: 1-16 quarter seconds, 17-255 whole seconds, 0 off.
// - Any non-zero timer code write starts the timer.
// - Shutdown bit turns regulator off after selected delay.
// - Timer expiry turns regulator back on per control register.
// - Shutdown delay codes: none, 250 ms, 1 s, 4 s when powered.
// - Alarm wake plus shutdown bit restores regulator on alarm.
// - Recovery bits 7, 6 pulse voltage and diagnostic clears.
// - Recovery bits 5, 4, 3 pulse short and discharge clears.
// - Recovery bits 2, 1 pulse charge and temperature clears.
// - Mask, timer, recovery readable always, writable only unlocked.
// - Regulator control: bit 3 enable, 3-bit voltage select.
`timescale 1ns/1ps
`include "subcmd_regs.svh"

module subcommand_data_fields
    import subcmd_pkg::*;
#(
    // Arbitrary identity values
    parameter logic [15:0] PART_ID_VALUE      = 16'h1234,
    parameter logic [15:0] FIRMWARE_MAJOR_MIN = 16'h0100,
    parameter logic [15:0] FIRMWARE_BUILD     = 16'h0001,
    parameter logic [15:0] SILICON_REVISION   = 16'h0001,
    // Arbitrary default unlock key
    parameter logic [15:0] UNLOCK_KEY_FIRST   = 16'h4a5b,
    parameter logic [15:0] UNLOCK_KEY_SECOND  = 16'hc6d7,
    // Timing
    parameter int unsigned TICK_CYCLES        = `WAKE_TICK_MS * `CLK_KHZ,
    parameter int unsigned KEY_WINDOW_CYCLES  = `UNLOCK_WINDOW_MS * `CLK_KHZ
) (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    // Subcommand port from host link engine
    input  wire subcmd_req_t        i_req,
    output subcmd_rsp_t             o_rsp,
    // Access level
    input  wire logic               i_seal,
    output logic                    o_unlocked_access_level,
    // Regulator
    input  wire logic [7:0]         i_regulator_control,
    input  wire logic               i_alarm_any,
    output regulator_setting_t      o_output_regulator,
    // Balancing and recovery
    output logic [7:0]              o_balance_cell_bits,
    output fault_recovery_t         o_fault_recovery
);

    localparam int WW = $clog2(KEY_WINDOW_CYCLES + 1);

    if (TICK_CYCLES < 1 || KEY_WINDOW_CYCLES < 1) begin : g_chk
        $error("Timing counts must be at least one");
    end

    function automatic logic [15:0] swap16(input logic [15:0] w);
        swap16 = {w[7:0], w[15:8]};
    endfunction

    // Registers
    logic [15:0]      unlock_key_first_word;
    logic [15:0]      unlock_key_second_word;
    wake_timer_ctrl_t wake_timer_control;
    fault_recovery_t  recovery_last;
    logic             key_armed;
    logic [WW-1:0]    key_window;

    // Request decode
    wire rd_req  = i_req.valid && !i_req.write;
    wire wr_req  = i_req.valid && i_req.write && o_unlocked_access_level;
    wire hit_bal = (i_req.code == `CMD_BALANCING_MASK);
    wire hit_tmr = (i_req.code == `CMD_WAKE_TIMER);
    wire hit_rec = (i_req.code == `CMD_FAULT_RECOVERY);
    wire hit_key = (i_req.code == `CMD_UNLOCK_KEY);

    wire wr_bal  = wr_req && hit_bal;
    wire wr_tmr  = wr_req && hit_tmr;
    wire wr_rec  = wr_req && hit_rec;
    wire wr_key  = wr_req && hit_key;

    wire [7:0] bal_in = i_req.data[7:0] & `BAL_VALID_MASK;
    wire wake_timer_ctrl_t tmr_in = i_req.data[`WT_CTRL_MSB:0];
    wire fault_recovery_t  rec_in = i_req.data[`REC_MSB:`REC_LSB];

    wire tmr_start = wr_tmr &&
                     (tmr_in.wake_timer_code != 8'h00);
    wire tmr_stop  = wr_tmr &&
                     (tmr_in.wake_timer_code == 8'h00);

    // Unlock sequence decode
    wire in_window   = (key_window < WW'(KEY_WINDOW_CYCLES));
    wire key_done    = i_req.valid && key_armed && in_window &&
                       (i_req.code == unlock_key_second_word);
    wire key_start   = i_req.valid && !o_unlocked_access_level &&
                       (i_req.code == unlock_key_first_word);

    // Regulator setting from its control register
    wire regulator_setting_t reg_ctrl = {
        i_regulator_control[`REG_EN_BIT],
        i_regulator_control[`REG_VOLT_MSB:`REG_VOLT_LSB]
    };

    logic tmr_hold_off;

    wake_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_wake_timer (
        .i_clk         (i_clk),
        .i_rst_b       (i_rst_b),
        .i_start       (tmr_start),
        .i_stop        (tmr_stop),
        .i_ctrl        (tmr_in),
        .i_reg_powered (reg_ctrl.enable),
        .i_alarm_any   (i_alarm_any),
        .o_running     (),
        .o_hold_off    (tmr_hold_off)
    );

    // Read answer select
    logic [2:0]  rd_len;
    logic [47:0] rd_data;

    always_comb begin
        rd_len  = `LEN_NONE;
        rd_data = 48'h000000000000;
        unique case (i_req.code)
            `CMD_PART_ID: begin
                rd_len  = `LEN_WORD;
                rd_data = {32'h00000000, PART_ID_VALUE};
            end
            `CMD_FIRMWARE_INFO: begin
                rd_len  = `LEN_FIRMWARE;
                rd_data = {swap16(FIRMWARE_BUILD),
                           swap16(FIRMWARE_MAJOR_MIN),
                           swap16(PART_ID_VALUE)};
            end
            `CMD_SILICON_REVISION: begin
                rd_len  = `LEN_WORD;
                rd_data = {32'h00000000, SILICON_REVISION};
            end
            `CMD_BALANCING_MASK: begin
                rd_len  = `LEN_BYTE;
                rd_data = {40'h0000000000, o_balance_cell_bits};
            end
            `CMD_WAKE_TIMER: begin
                rd_len  = `LEN_WORD;
                rd_data = {36'h000000000, wake_timer_control};
            end
            `CMD_FAULT_RECOVERY: begin
                rd_len  = `LEN_BYTE;
                rd_data = {40'h0000000000, recovery_last, 1'b0};
            end
            default: begin
                rd_len  = `LEN_NONE;
                rd_data = 48'h000000000000;
            end
        endcase
    end

    // Answer register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rsp <= '0;
        end else begin
            o_rsp.valid <= rd_req;
            o_rsp.len   <= rd_req ? rd_len : `LEN_NONE;
            o_rsp.data  <= rd_req ? rd_data : 48'h000000000000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_balance_cell_bits <= `BAL_RESET;
        end else if (wr_bal) begin
            o_balance_cell_bits <= bal_in;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fault_recovery <= `REC_RESET;
            recovery_last    <= `REC_RESET;
        end else begin
            o_fault_recovery <= wr_rec ? rec_in : `REC_RESET;
            if (wr_rec) begin
                recovery_last <= rec_in;
            end
        end
    end

    // Timer control field
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_timer_control <= `WT_CTRL_RESET;
        end else if (wr_tmr) begin
            wake_timer_control <= tmr_in;
        end
    end

    // regulator follows control unless held off
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_output_regulator <= '0;
        end else begin
            o_output_regulator.enable  <= reg_ctrl.enable && !tmr_hold_off;
            o_output_regulator.voltage <= reg_ctrl.voltage;
        end
    end

    // Key pair storage, writable only at full access
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            unlock_key_first_word  <= UNLOCK_KEY_FIRST;
            unlock_key_second_word <= UNLOCK_KEY_SECOND;
        end else if (wr_key) begin
            unlock_key_first_word  <= i_req.data[15:0];
            unlock_key_second_word <= i_req.data[31:16];
        end
    end

    // arm on first word; any other request disarms
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            key_armed  <= 1'b0;
            key_window <= '0;
        end else if (i_req.valid) begin
            key_armed  <= key_start && !key_done;
            key_window <= '0;
        end else if (key_armed) begin
            if (in_window) begin
                key_window <= key_window + WW'(1);
            end else begin
                key_armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_unlocked_access_level <= 1'b0;
        end else if (i_seal) begin
            o_unlocked_access_level <= 1'b0;
        end else if (key_done) begin
            o_unlocked_access_level <= 1'b1;
        end
    end

endmodule

// ---- dv/subcommand_data_fields_properties.sv ----
`timescale 1ns/1ps
`include "subcmd_regs.svh"

module subcommand_data_fields_checker
    import subcmd_pkg::*;
#(
    parameter logic [15:0] PART_ID_VALUE     = 16'h1234,
    parameter logic [15:0] UNLOCK_KEY_SECOND = 16'hc6d7
) (
    // Watched top ports
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire subcmd_req_t        i_req,
    input  wire subcmd_rsp_t        o_rsp,
    input  wire logic               o_unlocked_access_level,
    input  wire logic [7:0]         i_regulator_control,
    input  wire regulator_setting_t o_output_regulator,
    input  wire logic [7:0]         o_balance_cell_bits,
    input  wire fault_recovery_t    o_fault_recovery
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    wire rd_req   = i_req.valid && !i_req.write;
    wire wr_ok    = i_req.valid && i_req.write && o_unlocked_access_level;
    wire rec_wr   = wr_ok && i_req.code == `CMD_FAULT_RECOVERY;
    wire key2_req = i_req.valid && i_req.code == UNLOCK_KEY_SECOND;
    wire sd0_go   = wr_ok && i_req.code == `CMD_WAKE_TIMER
                    && i_req.data[11:8] == 4'h1
                    && i_req.data[7:0] != 8'h00 && i_regulator_control[3];

    property p_rsp_once;
        rd_req |=> o_rsp.valid;
    endproperty
    a_rsp_once: assert property (p_rsp_once) else $error("no answer");
    property p_rsp_cause;
        o_rsp.valid |-> $past(rd_req);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause) else $error("stray answer");
    property p_part_id;
        rd_req && i_req.code == `CMD_PART_ID |=> o_rsp.len == `LEN_WORD
            && o_rsp.data[15:0] == PART_ID_VALUE;
    endproperty
    a_part_id: assert property (p_part_id) else $error("part id bad");
    property p_fw;
        rd_req && i_req.code == `CMD_FIRMWARE_INFO |=> o_rsp.len == `LEN_FIRMWARE
            && o_rsp.data[15:0] == {PART_ID_VALUE[7:0], PART_ID_VALUE[15:8]};
    endproperty
    a_fw: assert property (p_fw) else $error("firmware answer bad");
    property p_bal_rsvd;
        (o_balance_cell_bits & ~`BAL_VALID_MASK) == 8'h00;
    endproperty
    a_bal_rsvd: assert property (p_bal_rsvd) else $error("mask rsvd set");
    property p_locked_wr;
        i_req.valid && i_req.write && !o_unlocked_access_level
            |=> $stable(o_balance_cell_bits);
    endproperty
    a_locked_wr: assert property (p_locked_wr) else $error("locked write");
    property p_bal_wr;
        wr_ok && i_req.code == `CMD_BALANCING_MASK |=> o_balance_cell_bits
            == ($past(i_req.data[7:0]) & `BAL_VALID_MASK);
    endproperty
    a_bal_wr: assert property (p_bal_wr) else $error("mask write bad");
    property p_rec;
        o_fault_recovery != 7'h00 |-> $past(rec_wr)
            && o_fault_recovery == $past(i_req.data[7:1]);
    endproperty
    a_rec: assert property (p_rec) else $error("recovery pulse bad");
    property p_unlock;
        $rose(o_unlocked_access_level) |-> $past(key2_req);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock cause");
    property p_reg_follow;
        o_output_regulator.enable |-> $past(i_regulator_control[3])
            && o_output_regulator.voltage == $past(i_regulator_control[2:0]);
    endproperty
    a_reg_follow: assert property (p_reg_follow) else $error("reg bad");
    property p_sd0;
        sd0_go |-> ##2 !o_output_regulator.enable;
    endproperty
    a_sd0: assert property (p_sd0) else $error("no shutdown");

    c_unlock: cover property ($rose(o_unlocked_access_level));
    c_rec: cover property (o_fault_recovery != 7'h00);
    c_reg_off: cover property ($fell(o_output_regulator.enable));
endmodule

bind subcommand_data_fields subcommand_data_fields_checker #(
    .PART_ID_VALUE    (PART_ID_VALUE),
    .UNLOCK_KEY_SECOND(UNLOCK_KEY_SECOND)
) i_chk (
    .i_clk                  (i_clk),
    .i_rst_b                (i_rst_b),
    .i_req                  (i_req),
    .o_rsp                  (o_rsp),
    .o_unlocked_access_level(o_unlocked_access_level),
    .i_regulator_control    (i_regulator_control),
    .o_output_regulator     (o_output_regulator),
    .o_balance_cell_bits    (o_balance_cell_bits),
    .o_fault_recovery       (o_fault_recovery)
);

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
`include "subcmd_regs.svh"

module host_model
    import subcmd_pkg::*;
(
    // Clock and answer
    input  wire logic        i_clk,
    input  wire subcmd_rsp_t i_rsp,
    // Request
    output subcmd_req_t      o_req
);
    initial o_req = '0;

    task automatic xfer(input logic w, input logic [15:0] c,
                        input logic [31:0] d);
        @(negedge i_clk);
        o_req <= '{valid: 1'b1, write: w, code: c, data: d};
        @(negedge i_clk);
        // Released bus shows inverted data, not stale values
        o_req <= '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
    endtask

    task automatic rd(input logic [15:0] c, output subcmd_rsp_t r);
        xfer(1'b0, c, 32'h0);
        r = i_rsp;
    endtask

    // first word, second word straight after
    task automatic unlock(input logic [15:0] k1, input logic [15:0] k2);
        xfer(1'b1, k1, {k2, k1});
        xfer(1'b1, k2, {k2, k1});
    endtask

    // reserved mask bits sent as zero
    task automatic set_mask(input logic [7:0] m);
        xfer(1'b1, `CMD_BALANCING_MASK, {24'h0, m & `BAL_VALID_MASK});
    endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`include "subcmd_regs.svh"
`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("[FAIL] %s exp=%0h got=%0h", nm, (e), (g)); \
        end \
    end

module tb;
    import subcmd_pkg::*;
    localparam logic [15:0] PID = 16'h5a3c;
    localparam logic [15:0] FWV = 16'h0203;
    localparam logic [15:0] BLD = 16'h0117;
    localparam logic [15:0] REV = 16'h00a1;
    localparam logic [15:0] K1  = 16'h7e21;
    localparam logic [15:0] K2  = 16'hd48f;
    localparam int          KW  = 50;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic               seal = 1'b0;
    logic               alarm = 1'b0;
    logic [7:0]         ctl = 8'h0e;
    subcmd_req_t        req;
    subcmd_rsp_t        rsp;
    subcmd_rsp_t        r;
    logic               unl;
    regulator_setting_t output_regulator;
    logic [7:0]         bal;
    fault_recovery_t    rec;
    int                 fails = 0;
    int                 compares = 0;

    always #4 clk = ~clk;

    subcommand_data_fields #(.PART_ID_VALUE(PID), .FIRMWARE_MAJOR_MIN(FWV),
        .FIRMWARE_BUILD(BLD), .SILICON_REVISION(REV), .UNLOCK_KEY_FIRST(K1),
        .UNLOCK_KEY_SECOND(K2), .TICK_CYCLES(4), .KEY_WINDOW_CYCLES(KW)
    ) i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_rsp(rsp),
        .i_seal(seal), .o_unlocked_access_level(unl),
        .i_regulator_control(ctl), .i_alarm_any(alarm),
        .o_output_regulator(output_regulator), .o_balance_cell_bits(bal),
        .o_fault_recovery(rec));

    host_model i_host (.i_clk(clk), .i_rsp(rsp), .o_req(req));

    task automatic summarize;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Timer write, then two timed looks at the regulator enable
    task automatic tmr(input logic [31:0] d, input int t1, input logic e1,
                       input int t2, input logic e2);
        i_host.xfer(1'b1, `CMD_WAKE_TIMER, d);
        wait_n(t1);
        `CHK("reg enable", e1, output_regulator.enable)
        wait_n(t2);
        `CHK("reg enable", e2, output_regulator.enable)
    endtask

    initial begin
        wait_n(5);
        rst_b = 1'b1;
        i_host.rd(`CMD_PART_ID, r);
        `CHK("part id", {`LEN_WORD, 32'h0, PID}, {r.len, r.data})
        i_host.rd(`CMD_FIRMWARE_INFO, r);
        `CHK("fw", {`LEN_FIRMWARE, BLD[7:0], BLD[15:8], FWV[7:0], FWV[15:8],
            PID[7:0], PID[15:8]}, {r.len, r.data})
        i_host.rd(`CMD_SILICON_REVISION, r);
        `CHK("revision", {`LEN_WORD, 32'h0, REV}, {r.len, r.data})
        i_host.rd(16'h0077, r);
        `CHK("unmapped", {`LEN_NONE, 48'h0}, {r.len, r.data})
        i_host.xfer(1'b1, `CMD_BALANCING_MASK, 32'h3e);
        `CHK("locked mask", 8'h00, bal)
        // Failed unlocks: intervening command, late word, wrong word
        i_host.xfer(1'b1, K1, 32'h0);
        i_host.rd(`CMD_PART_ID, r);
        i_host.xfer(1'b1, K2, 32'h0);
        `CHK("unlocked", 1'b0, unl)
        i_host.xfer(1'b1, K1, 32'h0);
        wait_n(KW + 10);
        i_host.xfer(1'b1, K2, 32'h0);
        `CHK("unlocked", 1'b0, unl)
        i_host.unlock(K1, K1);
        `CHK("unlocked", 1'b0, unl)
        i_host.unlock(K1, K2);
        `CHK("unlocked", 1'b1, unl)
        i_host.xfer(1'b1, `CMD_BALANCING_MASK, 32'hff);
        `CHK("mask", 8'h3e, bal)
        i_host.rd(`CMD_BALANCING_MASK, r);
        `CHK("mask rd", {`LEN_BYTE, 8'h3e}, {r.len, r.data[7:0]})
        i_host.set_mask(8'h00);
        `CHK("mask", 8'h00, bal)
        for (int b = 1; b < 8; b++) begin
            i_host.xfer(1'b1, `CMD_FAULT_RECOVERY, 32'h1 << b);
            `CHK("recovery", 7'h1 << (b - 1), rec)
            wait_n(1);
            `CHK("recovery", 7'h00, rec)
        end
        i_host.rd(`CMD_FAULT_RECOVERY, r);
        `CHK("recovery rd", {`LEN_BYTE, 8'h80}, {r.len, r.data[7:0]})
        i_host.xfer(1'b1, `CMD_FAULT_RECOVERY, 32'h01);
        `CHK("recovery", 7'h00, rec)
        for (int v = 0; v < 8; v++) begin
            ctl = {5'h01, 3'(v)};
            wait_n(2);
            `CHK("regulator", {1'b1, 3'(v)}, output_regulator)
        end
        ctl = 8'h0e;
        tmr(32'h0101, 1, 1'b0, 7, 1'b1);
        tmr(32'h0110, 60, 1'b0, 12, 1'b1);
        tmr(32'h0111, 76, 1'b0, 14, 1'b1);
        tmr(32'h0310, 2, 1'b1, 8, 1'b0);
        tmr(32'h0000, 2, 1'b1, 1, 1'b1);
        tmr(32'h0510, 10, 1'b1, 15, 1'b0);
        tmr(32'h0000, 2, 1'b1, 1, 1'b1);
        tmr(32'h0711, 40, 1'b1, 30, 1'b0);
        tmr(32'h0000, 2, 1'b1, 1, 1'b1);
        tmr(32'h0005, 2, 1'b1, 30, 1'b1);
        tmr(32'h0104, 10, 1'b0, 0, 1'b0);
        tmr(32'h0104, 12, 1'b0, 10, 1'b1);
        alarm = 1'b1;
        tmr(32'h0110, 4, 1'b0, 1, 1'b0);
        alarm = 1'b0;
        tmr(32'h0000, 2, 1'b1, 1, 1'b1);
        tmr(32'h0910, 2, 1'b0, 0, 1'b0);
        alarm = 1'b1;
        wait_n(4);
        `CHK("alarm wake", 1'b1, output_regulator.enable)
        alarm = 1'b0;
        i_host.xfer(1'b1, `CMD_WAKE_TIMER, 32'hf5ab);
        i_host.rd(`CMD_WAKE_TIMER, r);
        `CHK("timer rd", {`LEN_WORD, 16'h05ab}, {r.len, r.data[15:0]})
        i_host.xfer(1'b1, `CMD_WAKE_TIMER, 32'h0);
        seal = 1'b1;
        wait_n(1);
        seal = 1'b0;
        `CHK("unlocked", 1'b0, unl)
        i_host.set_mask(8'h02);
        `CHK("sealed mask", 8'h00, bal)
        summarize();
    end

    // Whole run is near 540 cycles; cut off well past that
    initial begin
        #(8 * 20000);
        fails++;
        summarize();
    end
endmodule
